// File: mon_regs_pkg.sv
package mon_regs_pkg;

  // system register encodings {op0,op1,crn,crm,op2}
  localparam logic [1:0] SYSREG_OP0 = 2'h3;
  localparam logic [2:0] SYSREG_OP1 = 3'h6;
  localparam logic [3:0] DBGCFG_CRN = 4'h1;
  localparam logic [3:0] DBGCFG_CRM = 4'h3;
  localparam logic [2:0] DBGCFG_OP2 = 3'h1;
  localparam logic [3:0] FAULT_CRN = 4'h6;
  localparam logic [3:0] FAULT_CRM = 4'h0;
  localparam logic [2:0] FAULT_OP2 = 3'h5;

  // debug config field positions
  localparam int PERF_TRAP_BIT = 6;
  localparam int DBG_EXT_BIT = 4;
  localparam int TRC_EXT_BIT = 3;
  localparam int PERF_EXT_BIT = 2;
  localparam int REALM_TRACE_BIT = 0;

  // fault address field positions
  localparam int SPACE_LOW_BIT = 63;
  localparam int SPACE_HIGH_BIT = 62;
  localparam int FPA_LO = 12;
  localparam int FPA_MID_HI = 47;
  localparam int FPA_EXT_LO = 48;
  localparam int FPA_EXT_HI = 51;

  // reset values
  localparam logic [63:0] DBGCFG_RESET = 64'h0;
  localparam logic [63:0] FAULT_RESET = 64'h0;

  // exception class syndromes
  localparam logic [5:0] EC_SYSREG64 = 6'h18;
  localparam logic [5:0] EC_MCR32 = 6'h03;
  localparam logic [5:0] EC_MCRR32 = 6'h04;

  // exception levels
  localparam logic [1:0] EL3 = 2'h3;

  // access kinds of a trapped monitor access
  typedef enum logic [1:0] {
    ACC_SYSREG64,
    ACC_MCR32,
    ACC_MCRR32
  } acc_kind_e;

  // physical address space codes {high,low}
  localparam logic [1:0] PAS_SECURE = 2'h0;
  localparam logic [1:0] PAS_NONSECURE = 2'h1;
  localparam logic [1:0] PAS_ROOT = 2'h2;
  localparam logic [1:0] PAS_REALM = 2'h3;

endpackage

// File: monitor_debug_trap_fault_regs.sv
// Overview of operation
// - perf trap bit traps lower-level monitor accesses
// - 64-bit trapped accesses report class 0x18
// - 32-bit single/double moves report 0x03/0x04
// - trap bit clear causes no trap
// - bit 4 gates debugger breakpoint access
// - bit 3 gates debugger trace access
// - bit 2 gates debugger perf access
// - realm trace bit clear prohibits realm tracing unless the auth interface overrides
// - realm trace bit sets debugger auth level
// - debug config reached by its encoding
// - lower-level accesses to either are undefined
// - fault register captures protection fault address
// - fault register exists only with realm feature
// - exception return leaves fault register unknown
// - space select bits at 63 and 62
// - space codes secure, nonsecure, root, realm
// - bits 47:12 hold address, above width zero
// - bits 51:48 only with large addresses
// - fault register reached by its encoding
module monitor_debug_trap_fault_regs #(
  parameter bit REALM_PRESENT = 1'b1,
  parameter bit PMU_PRESENT = 1'b1,
  parameter bit TRBE_PRESENT = 1'b1,
  parameter bit EXT_TRACE_IF = 1'b1,
  parameter bit EXT_PMU_IF = 1'b1,
  parameter bit TRF_PRESENT = 1'b1,
  parameter bit LPA_PRESENT = 1'b0,
  parameter int PA_BITS = 48
) (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic clk_en_i,
  // system register access port
  input wire logic sys_req_i,
  input wire logic sys_write_i,
  input wire logic [1:0] sys_el_i,
  input wire logic [1:0] sys_op0_i,
  input wire logic [2:0] sys_op1_i,
  input wire logic [3:0] sys_crn_i,
  input wire logic [3:0] sys_crm_i,
  input wire logic [2:0] sys_op2_i,
  input wire logic [63:0] sys_wdata_i,
  output logic sys_hit_o,
  output logic sys_undef_o,
  output logic [63:0] sys_rdata_o,
  // lower-level performance monitor access check
  input wire logic pmu_acc_i,
  input wire logic [1:0] pmu_acc_el_i,
  input wire logic [1:0] pmu_acc_kind_i,
  input wire logic hyp_perf_trap_i,
  output logic pmu_trap_o,
  output logic [5:0] pmu_trap_ec_o,
  // external debugger gating
  input wire logic ext_debug_disable_base_i,
  input wire logic ext_trace_disable_base_i,
  input wire logic ext_perf_disable_base_i,
  output logic [1:0] ext_debug_ctl_o,
  output logic [1:0] ext_trace_ctl_o,
  output logic [1:0] ext_perf_ctl_o,
  // realm trace
  input wire logic realm_state_i,
  input wire logic trace_auth_override_i,
  output logic realm_trace_ok_o,
  output logic ext_trace_auth_realm_o,
  // protection fault capture
  input wire logic gpc_fault_i,
  input wire logic [51:0] gpc_fault_pa_i,
  input wire logic [1:0] gpc_fault_pas_i,
  input wire logic el3_eret_i
);

  typedef struct packed {
    logic [63:0] dbg_cfg;
    logic [63:0] fault_addr;
    logic [63:0] rdata;
    logic hit;
    logic undef;
    logic trap;
    logic [5:0] ec;
  } state_s;

  state_s state_reg;
  state_s state_next;

  logic [63:0] dbg_mask;
  logic [63:0] fault_mask;
  logic sel_dbg;
  logic sel_fault;

  // writable bit masks; absent features make their fields zero
  always_comb begin
    dbg_mask = 64'h0;
    dbg_mask[mon_regs_pkg::PERF_TRAP_BIT] = PMU_PRESENT;
    dbg_mask[mon_regs_pkg::DBG_EXT_BIT] = REALM_PRESENT;
    dbg_mask[mon_regs_pkg::TRC_EXT_BIT] = REALM_PRESENT & EXT_TRACE_IF & TRBE_PRESENT;
    dbg_mask[mon_regs_pkg::PERF_EXT_BIT] = REALM_PRESENT & PMU_PRESENT & EXT_PMU_IF;
    dbg_mask[mon_regs_pkg::REALM_TRACE_BIT] = REALM_PRESENT & TRF_PRESENT;
    fault_mask = 64'h0;
    fault_mask[mon_regs_pkg::SPACE_LOW_BIT] = 1'b1;
    fault_mask[mon_regs_pkg::SPACE_HIGH_BIT] = 1'b1;
    for (int b = mon_regs_pkg::FPA_LO; b <= mon_regs_pkg::FPA_MID_HI; b++) begin
      fault_mask[b] = (b < PA_BITS);
    end
    for (int b = mon_regs_pkg::FPA_EXT_LO; b <= mon_regs_pkg::FPA_EXT_HI; b++) begin
      fault_mask[b] = LPA_PRESENT && (b < PA_BITS);
    end
  end

  // decode of the two encodings
  assign sel_dbg = (sys_op0_i == mon_regs_pkg::SYSREG_OP0) &&
                   (sys_op1_i == mon_regs_pkg::SYSREG_OP1) &&
                   (sys_crn_i == mon_regs_pkg::DBGCFG_CRN) &&
                   (sys_crm_i == mon_regs_pkg::DBGCFG_CRM) &&
                   (sys_op2_i == mon_regs_pkg::DBGCFG_OP2);
  assign sel_fault = (sys_op0_i == mon_regs_pkg::SYSREG_OP0) &&
                     (sys_op1_i == mon_regs_pkg::SYSREG_OP1) &&
                     (sys_crn_i == mon_regs_pkg::FAULT_CRN) &&
                     (sys_crm_i == mon_regs_pkg::FAULT_CRM) &&
                     (sys_op2_i == mon_regs_pkg::FAULT_OP2);

  // next-state: register access, fault capture and trap decision
  always_comb begin
    state_next = state_reg;
    state_next.hit = 1'b0;
    state_next.undef = 1'b0;
    state_next.trap = 1'b0;
    state_next.ec = 6'h00;
    if (sys_req_i && sel_dbg) begin
      state_next.hit = 1'b1;
      if (sys_el_i != mon_regs_pkg::EL3) begin
        state_next.undef = 1'b1;
      end else if (sys_write_i) begin
        state_next.dbg_cfg = sys_wdata_i & dbg_mask;
      end else begin
        state_next.rdata = state_reg.dbg_cfg & dbg_mask;
      end
    end else if (sys_req_i && sel_fault) begin
      state_next.hit = 1'b1;
      if (!REALM_PRESENT || sys_el_i != mon_regs_pkg::EL3) begin
        state_next.undef = 1'b1;
      end else if (sys_write_i) begin
        state_next.fault_addr = sys_wdata_i & fault_mask;
      end else begin
        state_next.rdata = state_reg.fault_addr & fault_mask;
      end
    end
    // the eret value is unknown; zero is one legal choice, capture wins over it
    if (REALM_PRESENT && el3_eret_i) begin
      state_next.fault_addr = mon_regs_pkg::FAULT_RESET;
    end
    if (REALM_PRESENT && gpc_fault_i) begin
      state_next.fault_addr = {gpc_fault_pas_i[0], gpc_fault_pas_i[1], 10'h000,
                               gpc_fault_pa_i[51:12], 12'h000} & fault_mask;
    end
    // trap only lower levels, and only when the hypervisor trap does not take it first
    if (pmu_acc_i && state_reg.dbg_cfg[mon_regs_pkg::PERF_TRAP_BIT] &&
        pmu_acc_el_i != mon_regs_pkg::EL3 && !hyp_perf_trap_i) begin
      state_next.trap = 1'b1;
      unique case (mon_regs_pkg::acc_kind_e'(pmu_acc_kind_i))
        mon_regs_pkg::ACC_SYSREG64: state_next.ec = mon_regs_pkg::EC_SYSREG64;
        mon_regs_pkg::ACC_MCR32: state_next.ec = mon_regs_pkg::EC_MCR32;
        mon_regs_pkg::ACC_MCRR32: state_next.ec = mon_regs_pkg::EC_MCRR32;
        default: state_next.ec = 6'h00;
      endcase
    end
  end

  // state register; clock enable freezes everything
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg <= '{dbg_cfg: mon_regs_pkg::DBGCFG_RESET, fault_addr: mon_regs_pkg::FAULT_RESET,
                     rdata: 64'h0, hit: 1'b0, undef: 1'b0, trap: 1'b0, ec: 6'h00};
    end else if (clk_en_i) begin
      state_reg <= state_next;
    end
  end

  assign sys_hit_o = state_reg.hit;
  assign sys_undef_o = state_reg.undef;
  assign sys_rdata_o = state_reg.rdata;
  assign pmu_trap_o = state_reg.trap;
  assign pmu_trap_ec_o = state_reg.ec;

  // combined {extended,base} pairs for the debugger access decoder
  assign ext_debug_ctl_o = {state_reg.dbg_cfg[mon_regs_pkg::DBG_EXT_BIT],
                            ext_debug_disable_base_i};
  assign ext_trace_ctl_o = {state_reg.dbg_cfg[mon_regs_pkg::TRC_EXT_BIT],
                            ext_trace_disable_base_i};
  assign ext_perf_ctl_o = {state_reg.dbg_cfg[mon_regs_pkg::PERF_EXT_BIT],
                           ext_perf_disable_base_i};

  // realm tracing: bit clear prohibits unless the auth interface overrides
  assign realm_trace_ok_o = !realm_state_i ||
                            state_reg.dbg_cfg[mon_regs_pkg::REALM_TRACE_BIT] ||
                            trace_auth_override_i;
  assign ext_trace_auth_realm_o = state_reg.dbg_cfg[mon_regs_pkg::REALM_TRACE_BIT];

endmodule

// File: mon_chk_sva.sv
module mon_chk (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic clk_en_i,
  input wire logic sys_req_i,
  input wire logic sys_write_i,
  input wire logic [1:0] sys_el_i,
  input wire logic [3:0] sys_crn_i,
  input wire logic sys_hit_o,
  input wire logic sys_undef_o,
  input wire logic [63:0] sys_rdata_o,
  input wire logic pmu_acc_i,
  input wire logic [1:0] pmu_acc_el_i,
  input wire logic [1:0] pmu_acc_kind_i,
  input wire logic hyp_perf_trap_i,
  input wire logic pmu_trap_o,
  input wire logic [5:0] pmu_trap_ec_o,
  input wire logic ext_perf_disable_base_i,
  input wire logic [1:0] ext_perf_ctl_o,
  input wire logic realm_state_i,
  input wire logic trace_auth_override_i,
  input wire logic realm_trace_ok_o,
  input wire logic ext_trace_auth_realm_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  // a trap needs a live lower-level access that the hypervisor trap did not take
  property p_trap;
    pmu_trap_o |-> $past(pmu_acc_i && clk_en_i && !hyp_perf_trap_i) && $past(pmu_acc_el_i) != 2'h3;
  endproperty
  a_trap: assert property (p_trap) else $error("trap without cause");
  property p_ec64;
    pmu_trap_o && $past(pmu_acc_kind_i) == 2'h0 |-> pmu_trap_ec_o == 6'h18;
  endproperty
  a_ec64: assert property (p_ec64) else $error("wrong 64-bit class");
  // single moves give 0x03 and double moves 0x04, the kind code plus two
  property p_ec32;
    pmu_trap_o && $past(pmu_acc_kind_i) inside {2'h1, 2'h2} |->
      pmu_trap_ec_o == {4'h0, $past(pmu_acc_kind_i)} + 6'h2;
  endproperty
  a_ec32: assert property (p_ec32) else $error("wrong 32-bit class");
  property p_undef;
    sys_req_i && clk_en_i && sys_el_i != 2'h3 |=> sys_undef_o == sys_hit_o;
  endproperty
  a_undef: assert property (p_undef) else $error("lower level not undefined");
  // reserved fault bits stay clear; large addresses are off in this build
  property p_fault_rsv;
    sys_hit_o && !sys_undef_o && $past(!sys_write_i && sys_crn_i == 4'h6) |->
      sys_rdata_o[61:48] == 14'h0 && sys_rdata_o[11:0] == 12'h0;
  endproperty
  a_fault_rsv: assert property (p_fault_rsv) else $error("fault reserved set");
  property p_cfg_rsv;
    sys_hit_o && !sys_undef_o && $past(!sys_write_i && sys_crn_i == 4'h1) |->
      (sys_rdata_o & ~64'h5D) == 64'h0;
  endproperty
  a_cfg_rsv: assert property (p_cfg_rsv) else $error("config reserved set");
  property p_ext;
    ext_perf_ctl_o[0] == ext_perf_disable_base_i;
  endproperty
  a_ext: assert property (p_ext) else $error("base disable lost");
  property p_realm;
    realm_trace_ok_o == (!realm_state_i || ext_trace_auth_realm_o || trace_auth_override_i);
  endproperty
  a_realm: assert property (p_realm) else $error("realm trace wrong");
endmodule
bind monitor_debug_trap_fault_regs mon_chk chk (.*);

// File: monitor_debug_trap_fault_regs_tb.sv
module monitor_debug_trap_fault_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk_i = 1'h0, arst_n_i = 1'h0, clk_en_i = 1'h1, sys_req_i = 1'h0, sys_write_i = 1'h0;
  logic [1:0] sys_el_i = 2'h3, sys_op0_i = 2'h3, pmu_acc_el_i = 2'h0, pmu_acc_kind_i = 2'h0;
  logic [1:0] gpc_fault_pas_i = 2'h0;
  logic [2:0] sys_op1_i = 3'h6, sys_op2_i = 3'h1;
  logic [3:0] sys_crn_i = 4'h1, sys_crm_i = 4'h3;
  logic [63:0] sys_wdata_i = 64'h0, sys_rdata_o, d;
  logic [51:0] gpc_fault_pa_i = 52'h0;
  logic pmu_acc_i = 1'h0, hyp_perf_trap_i = 1'h0, gpc_fault_i = 1'h0, el3_eret_i = 1'h0;
  logic ext_debug_disable_base_i = 1'h0, ext_trace_disable_base_i = 1'h0;
  logic ext_perf_disable_base_i = 1'h0, realm_state_i = 1'h0, trace_auth_override_i = 1'h0;
  logic sys_hit_o, sys_undef_o, pmu_trap_o, realm_trace_ok_o, ext_trace_auth_realm_o, k;
  logic [5:0] pmu_trap_ec_o;
  logic [1:0] ext_debug_ctl_o, ext_trace_ctl_o, ext_perf_ctl_o;
  logic [31:0] seed = 32'h8BAE5B7C, t;
  int error_cnt = 0, comparisons = 0;
  monitor_debug_trap_fault_regs dut (.*);
  // 100 ns clock
  initial begin
    forever #50 core_clk_i = ~core_clk_i;
  end
  // xorshift keeps the random stream repeatable
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task close_out();
    $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // one request; crn picks config, fault or an unmapped slot; answer is one cycle later
  task sys(input logic w, input logic [1:0] el, input logic [3:0] crn, input logic [63:0] wd,
           input logic hit, input logic und);
    @(posedge core_clk_i) #1;
    sys_req_i = 1'h1;
    sys_write_i = w;
    sys_el_i = el;
    sys_crn_i = crn;
    sys_crm_i = (crn == 4'h6) ? 4'h0 : 4'h3;
    sys_op2_i = (crn == 4'h6) ? 3'h5 : 3'h1;
    sys_wdata_i = wd;
    @(posedge core_clk_i) #1;
    sys_req_i = 1'h0;
    chk(64'({sys_hit_o, sys_undef_o}), 64'({hit, und}));
  endtask
  initial begin
    repeat (10) @(posedge core_clk_i);
    #1 arst_n_i = 1'h1;
    sys(1'h0, 2'h3, 4'h6, 64'h0, 1'h1, 1'h0);
    chk(sys_rdata_o, 64'h0);
    $display("reset test done");
    // random writes at EL3, refused lower-level writes, read back through the mask
    for (int i = 0; i < 12; i++) begin
      d = {rnd(), rnd()};
      t = rnd();
      {ext_debug_disable_base_i, ext_trace_disable_base_i, ext_perf_disable_base_i} = t[2:0];
      {realm_state_i, trace_auth_override_i} = t[4:3];
      sys(1'h1, 2'h3, i[0] ? 4'h6 : 4'h1, d, 1'h1, 1'h0);
      sys(1'h1, 2'(t[6:5] % 3), i[0] ? 4'h6 : 4'h1, ~d, 1'h1, 1'h1);
      sys(1'h0, 2'h3, i[0] ? 4'h6 : 4'h1, 64'h0, 1'h1, 1'h0);
      chk(sys_rdata_o, d & (i[0] ? 64'hC000_FFFF_FFFF_F000 : 64'h5D));
      if (!i[0]) chk(64'({ext_debug_ctl_o, ext_trace_ctl_o, ext_perf_ctl_o, realm_trace_ok_o,
        ext_trace_auth_realm_o}), 64'({d[4], t[2], d[3], t[1], d[2], t[0],
        !t[4] | d[0] | t[3], d[0]}));
    end
    sys(1'h0, 2'h3, 4'h2, 64'h0, 1'h0, 1'h0);
    // clock enable low: a write is neither answered nor applied
    sys(1'h1, 2'h3, 4'h1, 64'h11, 1'h1, 1'h0);
    @(posedge core_clk_i) #1;
    clk_en_i = 1'h0;
    sys(1'h1, 2'h3, 4'h1, 64'h5D, 1'h0, 1'h0);
    clk_en_i = 1'h1;
    sys(1'h0, 2'h3, 4'h1, 64'h0, 1'h1, 1'h0);
    chk(sys_rdata_o, 64'h11);
    $display("register test done");
    // trap bit clear then set, random level, kind and hypervisor trap
    for (int b = 0; b < 2; b++) begin
      sys(1'h1, 2'h3, 4'h1, 64'(b) << 6, 1'h1, 1'h0);
      repeat (24) begin
        t = rnd();
        @(posedge core_clk_i) #1;
        pmu_acc_i = 1'h1;
        pmu_acc_el_i = t[1:0];
        pmu_acc_kind_i = t[3] ? 2'h2 : {1'h0, t[2]};
        hyp_perf_trap_i = t[4];
        @(posedge core_clk_i) #1;
        pmu_acc_i = 1'h0;
        k = (b == 1) && t[1:0] != 2'h3 && !t[4];
        chk(64'({pmu_trap_o, pmu_trap_ec_o}), 64'({k, !k ? 6'h0 : t[3] ? 6'h04 :
          t[2] ? 6'h03 : 6'h18}));
      end
    end
    $display("trap test done");
    // capture each address space code, then an exception return wipes it
    for (int p = 0; p < 4; p++) begin
      d = {rnd(), rnd()};
      @(posedge core_clk_i) #1;
      gpc_fault_i = 1'h1;
      gpc_fault_pa_i = d[51:0];
      gpc_fault_pas_i = 2'(p);
      @(posedge core_clk_i) #1;
      gpc_fault_i = 1'h0;
      sys(1'h0, 2'h3, 4'h6, 64'h0, 1'h1, 1'h0);
      chk(sys_rdata_o, {p[0], p[1], 14'h0, d[47:12], 12'h0});
    end
    @(posedge core_clk_i) #1;
    el3_eret_i = 1'h1;
    @(posedge core_clk_i) #1;
    el3_eret_i = 1'h0;
    sys(1'h0, 2'h3, 4'h6, 64'h0, 1'h1, 1'h0);
    chk(sys_rdata_o, 64'h0);
    $display("fault test done");
    close_out();
  end
endmodule
